/* File: hdl/acd_map.svh */
// register offsets, field positions and codes of the comparator control block
`ifndef ACD_MAP_SVH
`define ACD_MAP_SVH
`define ACD_AW            12
`define ACD_ADDR_CTRL0    12'h000
`define ACD_ADDR_CTRL1    12'h004
`define ACD_ADDR_FLAG     12'h008
`define ACD_ADDR_SUMMARY  12'h00c
`define ACD_ADDR_PINSEL   12'h010
`define ACD_C0_ON         7
`define ACD_C0_OUT        6
`define ACD_C0_POL        4
`define ACD_C0_HYS        1
`define ACD_C0_SYNC       0
`define ACD_C1_INTP       1
`define ACD_C1_INTN       0
`define ACD_FLAG_BIT      0
`define ACD_SUM_BIT       0
`define ACD_PIN_DIR_BIT   7
`define ACD_PPS_W         5
`define ACD_PPS_CMP       5'h0c
`define ACD_PPS_RST       5'h00
`define ACD_PIN_DIR_RST   1'b1
`endif

/* File: hdl/acd_pkg.sv */
// types shared by the comparator control block
package acd_pkg;
    // control lines towards the analog comparator core
    typedef struct packed {
        logic enable;
        logic hys;
    } acd_core_ctl_s;

    // whole state of the control block
    typedef struct packed {
        logic                 on;
        logic                 pol;
        logic                 hys;
        logic                 sync;
        logic                 intp;
        logic                 intn;
        logic                 flag;
        logic                 out;
        logic                 out_prev;
        logic                 cmp_f;
        logic                 tclk_f;
        logic                 gate;
        logic                 pin;
        logic                 pin_oe;
        logic                 pin_dir;
        logic [4:0]           pps;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } acd_state_s;
endpackage : acd_pkg

/* File: hdl/acd_sync3.sv */
// three-stage synchroniser exposing its second and third stages
`timescale 1ns/1ps
module acd_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q_mid,
    output logic      [W-1:0] q_last
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] mid;
        logic [W-1:0] last;
    } acd_sync_s;

    acd_sync_s st_reg;
    acd_sync_s st_next;

    // first stage feeds only the second; no logic between stages
    always_comb begin
        st_next      = st_reg;
        st_next.s1   = d;
        st_next.mid  = st_reg.s1;
        st_next.last = st_reg.mid;
    end

    // one state register for all three stages
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // stages two and three leave as plain register copies
    assign q_mid  = st_reg.mid;
    assign q_last = st_reg.last;
endmodule : acd_sync3

/* File: hdl/acd_top.sv */
// comparator digital control: apb registers, polarity, edge flag, timer gate, pin
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "acd_map.svh"

// How it works
// [R1] raw compare is high when noninverting input exceeds inverting input
// [R2] enable bit powers the comparator; cleared it is off and output equals the polarity bit
// [R3] result readable in control register and in the summary register
// [R4] pin carries the result when its source select picks the comparator
// [R5] software clears the pin direction bit to make the pin an output
// [R6] output latched each clock; outside outputs follow unless synchronised
// [R7] polarity bit set inverts the output; clear passes it through
// [R8] output bit equals raw compare xor polarity bit
// [R9] hysteresis bit switches the core hysteresis on
// [R10] result drives the timer gate source output
// [R11] software should enable synchronisation when gating the timer
// [R12] in sync mode gate and pin update on timer clock falling edge
// [R13] enabled rising or falling output edge sets the irq flag
// [R14] software clears the flag by writing one; a new edge wins
// [R15] edges found by comparing latched output to its previous value
module acd_top (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [`ACD_AW-1:0]   paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 cmp_raw,
    input  wire logic                 timer_clk_src,
    output acd_pkg::acd_core_ctl_s    core_ctl,
    output logic                      timer_gate,
    output logic                      pin_out,
    output logic                      pin_oe,
    output logic                      comparator_irq_flag
);
    acd_pkg::acd_state_s r_reg;
    acd_pkg::acd_state_s r_next;
    logic [1:0]          s_mid;
    logic [1:0]          s_last;
    logic                cmp_agree;
    logic                tclk_agree;
    logic                tfall;
    logic                ext_val;
    logic                rise_ev;
    logic                fall_ev;
    logic                acc_first;
    logic                wr_take;
    logic                flag_clr;
    logic [31:0]         rd;
    logic                mapped;

    // both pins are asynchronous to clk, so each passes three stages
    acd_sync3 #(
        .W (2)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({timer_clk_src, cmp_raw}),
        .q_mid   (s_mid),
        .q_last  (s_last)
    );

    // a change counts only once stages two and three agree
    assign cmp_agree  = (s_mid[0] == s_last[0]);
    assign tclk_agree = (s_mid[1] == s_last[1]);
    // falling edge of the (post-prescaler) timer source clock
    assign tfall      = r_reg.tclk_f & tclk_agree & ~s_last[1];

    // [R1] disabled core reads low, enabled core gives raw compare
    // [R8] polarity applied by xor
    assign ext_val = (r_reg.on & r_reg.cmp_f) ^ r_reg.pol;

    // [R15] edge seen between latched value and its previous copy
    assign rise_ev = r_reg.out & ~r_reg.out_prev;
    assign fall_ev = ~r_reg.out & r_reg.out_prev;

    // apb: answer one cycle into the access phase, act when pready is seen
    assign acc_first = psel & penable & ~r_reg.pready;
    assign wr_take   = psel & penable & r_reg.pready & pwrite;
    assign flag_clr  = wr_take & (paddr == `ACD_ADDR_FLAG) & pwdata[`ACD_FLAG_BIT];

    // read mux; unimplemented bits read zero
    always_comb begin
        rd     = 32'h0;
        mapped = 1'b1;
        case (paddr)
            `ACD_ADDR_CTRL0: begin
                rd[`ACD_C0_ON]   = r_reg.on;
                // [R3] output bit in the control register
                rd[`ACD_C0_OUT]  = r_reg.out;
                rd[`ACD_C0_POL]  = r_reg.pol;
                rd[`ACD_C0_HYS]  = r_reg.hys;
                rd[`ACD_C0_SYNC] = r_reg.sync;
            end
            `ACD_ADDR_CTRL1: begin
                rd[`ACD_C1_INTP] = r_reg.intp;
                rd[`ACD_C1_INTN] = r_reg.intn;
            end
            `ACD_ADDR_FLAG: begin
                rd[`ACD_FLAG_BIT] = r_reg.flag;
            end
            `ACD_ADDR_SUMMARY: begin
                // [R3] shared mirror of the same latched output
                rd[`ACD_SUM_BIT] = r_reg.out;
            end
            `ACD_ADDR_PINSEL: begin
                rd[`ACD_PPS_W-1:0]    = r_reg.pps;
                rd[`ACD_PIN_DIR_BIT]  = r_reg.pin_dir;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // next-state logic for the whole block
    always_comb begin
        r_next         = r_reg;
        r_next.pready  = acc_first;
        r_next.pslverr = acc_first & ~mapped;
        if (acc_first) begin
            r_next.prdata = rd;
        end
        // register writes land at the edge that sees pready
        if (wr_take) begin
            case (paddr)
                `ACD_ADDR_CTRL0: begin
                    // [R2] enable bit
                    r_next.on   = pwdata[`ACD_C0_ON];
                    // [R7] polarity bit
                    r_next.pol  = pwdata[`ACD_C0_POL];
                    // [R9] hysteresis bit
                    r_next.hys  = pwdata[`ACD_C0_HYS];
                    r_next.sync = pwdata[`ACD_C0_SYNC];
                end
                `ACD_ADDR_CTRL1: begin
                    r_next.intp = pwdata[`ACD_C1_INTP];
                    r_next.intn = pwdata[`ACD_C1_INTN];
                end
                `ACD_ADDR_PINSEL: begin
                    r_next.pps     = pwdata[`ACD_PPS_W-1:0];
                    r_next.pin_dir = pwdata[`ACD_PIN_DIR_BIT];
                end
                default: begin
                    r_next.pps = r_reg.pps;
                end
            endcase
        end
        // filtered copies of the pins
        r_next.cmp_f  = cmp_agree ? s_last[0] : r_reg.cmp_f;
        r_next.tclk_f = tclk_agree ? s_last[1] : r_reg.tclk_f;
        // [R6] internal output latched every cycle
        r_next.out      = ext_val;
        r_next.out_prev = r_reg.out;
        // [R14] clear first, so a same-cycle edge leaves the flag set
        if (flag_clr) begin
            r_next.flag = 1'b0;
        end
        // [R13] enabled edges set the flag
        if ((rise_ev & r_reg.intp) | (fall_ev & r_reg.intn)) begin
            r_next.flag = 1'b1;
        end
        // [R12] sync mode holds the gate until a timer clock falling edge
        // [R10] gate source follows the result otherwise
        if (!r_reg.sync || tfall) begin
            r_next.gate = ext_val;
        end
        // [R4] pin follows the gate value only when routed to it
        // [R5] driver stays off while the direction bit reads input
        r_next.pin    = (r_reg.pps == `ACD_PPS_CMP) & r_next.gate;
        r_next.pin_oe = (r_reg.pps == `ACD_PPS_CMP) & ~r_reg.pin_dir;
    end

    // single state register; every output comes from it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_reg         <= '0;
            r_reg.pps     <= `ACD_PPS_RST;
            r_reg.pin_dir <= `ACD_PIN_DIR_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // [R2] core enable and hysteresis straight from register bits
    assign core_ctl            = '{enable: r_reg.on, hys: r_reg.hys};
    assign prdata              = r_reg.prdata;
    assign pready              = r_reg.pready;
    assign pslverr             = r_reg.pslverr;
    assign timer_gate          = r_reg.gate;
    assign pin_out             = r_reg.pin;
    assign pin_oe              = r_reg.pin_oe;
    assign comparator_irq_flag = r_reg.flag;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_rise_enabled;
        r_reg.out && !r_reg.out_prev && r_reg.intp;
    endsequence

    sequence s_clear_write;
        psel && penable && pready && pwrite && (paddr == `ACD_ADDR_FLAG)
            && pwdata[`ACD_FLAG_BIT];
    endsequence

    a_out_plain: assert property ( // [R1]
        (r_reg.on && !r_reg.pol && r_reg.cmp_f) |=> r_reg.out)
        else $error("output low though compare high and polarity clear");
    a_out_inverted: assert property ( // [R8]
        (r_reg.on && r_reg.pol && r_reg.cmp_f) |=> !r_reg.out)
        else $error("output not inverted with polarity set");
    a_disabled_low: assert property ( // [R2]
        (!r_reg.on && !r_reg.pol) |=> !r_reg.out)
        else $error("disabled comparator output not low");
    a_apb_answer: assert property ( // [R3]
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle long");
    a_summary_mirror: assert property ( // [R3]
        (psel && penable && !pready && !pwrite && paddr == `ACD_ADDR_SUMMARY)
            |=> prdata[`ACD_SUM_BIT] == $past(r_reg.out))
        else $error("summary read differs from latched output");
    a_edge_sets_flag: assert property ( // [R13]
        s_rise_enabled |=> comparator_irq_flag)
        else $error("enabled rising edge did not set flag");
    a_set_wins_clear: assert property ( // [R14]
        (s_clear_write and s_rise_enabled) |=> comparator_irq_flag)
        else $error("edge lost during flag clear");
    a_sync_hold_gate: assert property ( // [R12]
        (r_reg.sync && !tfall) |=> $stable(timer_gate))
        else $error("synchronised gate moved without timer falling edge");
    a_async_gate: assert property ( // [R10]
        !r_reg.sync |=> timer_gate == $past(ext_val))
        else $error("asynchronous gate does not follow result");
    a_pin_unrouted: assert property ( // [R4]
        (r_reg.pps != `ACD_PPS_CMP) |=> (!pin_out && !pin_oe))
        else $error("pin driven while not routed");
    a_hys_write: assert property ( // [R9]
        (psel && penable && pready && pwrite && paddr == `ACD_ADDR_CTRL0)
            |=> core_ctl.hys == $past(pwdata[`ACD_C0_HYS]))
        else $error("hysteresis bit not taken");
endmodule : acd_top

/* File: tb/acd_analog_model.sv */
// behavioural analog comparator core and prescaled timer clock source
`timescale 1ns/1ps
module acd_analog_model #(
    parameter int HYS_MV    = 10,
    parameter int TCLK_HALF = 170
) (
    input  wire acd_pkg::acd_core_ctl_s core_ctl,
    input  wire logic [7:0]             vp,
    input  wire logic [7:0]             vn,
    input  wire logic                   tclk_run,
    output logic                        cmp_raw,
    output logic                        timer_clk_src
);
    int margin;
    // compare with optional hysteresis, dead when off
    // reset drives core_ctl to zero, which wakes this and clears the output
    always @(core_ctl or vp or vn) begin
        margin = core_ctl.hys ? HYS_MV : 0;
        if (core_ctl.enable !== 1'b1)
            cmp_raw = 1'b0;
        else if (int'(vp) > int'(vn) + margin)
            cmp_raw = 1'b1;
        else if (int'(vp) + margin < int'(vn))
            cmp_raw = 1'b0;
    end
    // clock parks high when stopped, so no stray falling edge appears
    initial begin
        timer_clk_src = 1'b1;
        forever begin
            #(TCLK_HALF);
            if (tclk_run || !timer_clk_src)
                timer_clk_src = ~timer_clk_src;
        end
    end
endmodule : acd_analog_model

/* File: tb/tb.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "acd_map.svh"
module tb;
    localparam logic [31:0] b_en  = 32'h1 << `ACD_C0_ON;
    localparam logic [31:0] b_pol = 32'h1 << `ACD_C0_POL;
    localparam logic [31:0] b_hys = 32'h1 << `ACD_C0_HYS;
    localparam logic [31:0] b_syn = 32'h1 << `ACD_C0_SYNC;
    localparam logic [31:0] b_dir = 32'h1 << `ACD_PIN_DIR_BIT;
    localparam logic [31:0] b_cmp = {27'h0, `ACD_PPS_CMP};
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, er, e;
    logic cmp_raw, timer_clk_src, timer_gate, pin_out, pin_oe, comparator_irq_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  vp, vn;
    logic        tclk_run;
    acd_pkg::acd_core_ctl_s core_ctl;
    int err_total, cmp_count, cycles;
    acd_top u_acd_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_raw(cmp_raw), .timer_clk_src(timer_clk_src),
        .core_ctl(core_ctl), .timer_gate(timer_gate), .pin_out(pin_out), .pin_oe(pin_oe),
        .comparator_irq_flag(comparator_irq_flag));
    acd_analog_model u_acd_analog_model (.core_ctl(core_ctl), .vp(vp), .vn(vn),
        .tclk_run(tclk_run), .cmp_raw(cmp_raw), .timer_clk_src(timer_clk_src));
    always #20 clk = ~clk;
    task automatic finish_test();
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one apb transfer; waits for pready, bounded so a dead slave is reported
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // output bit and flag settle within a dozen cycles of an input change
    task automatic settle();
        repeat (12) @(posedge clk);
    endtask : settle
    task automatic t_reset();
        logic [11:0] at [5];
        logic [31:0] vt [5];
        at = '{`ACD_ADDR_CTRL0, `ACD_ADDR_CTRL1, `ACD_ADDR_FLAG, `ACD_ADDR_SUMMARY,
               `ACD_ADDR_PINSEL};
        vt = '{32'h0, 32'h0, 32'h0, 32'h0, b_dir};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, at[i], 32'h0);
            chk("reset_value", vt[i], rd);
        end
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("pin_oe_reset", 32'h0, {31'h0, pin_oe});
    endtask : t_reset
    task automatic t_polarity();
        for (int p = 0; p < 2; p++) begin
            for (int h = 0; h < 2; h++) begin
                apb(1'b1, `ACD_ADDR_CTRL0, b_en | (p != 0 ? b_pol : 32'h0));
                vp <= (h != 0) ? 8'hc8 : 8'h32;
                vn <= 8'h64;
                settle();
                e = (h != 0) ^ (p != 0);
                apb(1'b0, `ACD_ADDR_CTRL0, 32'h0);
                chk("out_bit", {31'h0, e}, {31'h0, rd[`ACD_C0_OUT]});
                apb(1'b0, `ACD_ADDR_SUMMARY, 32'h0);
                chk("summary", {31'h0, e}, rd);
                chk("gate", {31'h0, e}, {31'h0, timer_gate});
            end
        end
        apb(1'b1, `ACD_ADDR_CTRL0, b_pol | b_hys);
        settle();
        chk("core_ctl", 32'h1, {30'h0, core_ctl});
        apb(1'b0, `ACD_ADDR_CTRL0, 32'h0);
        chk("off_out", 32'h1, {31'h0, rd[`ACD_C0_OUT]});
    endtask : t_polarity
    task automatic t_edges();
        vp <= 8'h32;
        apb(1'b1, `ACD_ADDR_CTRL1, 32'h1 << `ACD_C1_INTP);
        apb(1'b1, `ACD_ADDR_CTRL0, b_en);
        settle();
        apb(1'b1, `ACD_ADDR_FLAG, 32'h1);
        vp <= 8'hc8;
        settle();
        chk("flag_rise", 32'h1, {31'h0, comparator_irq_flag});
        apb(1'b1, `ACD_ADDR_FLAG, 32'h1);
        apb(1'b0, `ACD_ADDR_FLAG, 32'h0);
        chk("flag_clear", 32'h0, rd);
        vp <= 8'h32;
        settle();
        chk("flag_fall_off", 32'h0, {31'h0, comparator_irq_flag});
        apb(1'b1, `ACD_ADDR_CTRL1, 32'h1 << `ACD_C1_INTN);
        vp <= 8'hc8;
        settle();
        chk("flag_rise_off", 32'h0, {31'h0, comparator_irq_flag});
        vp <= 8'h32;
        settle();
        chk("flag_fall", 32'h1, {31'h0, comparator_irq_flag});
        apb(1'b1, `ACD_ADDR_FLAG, 32'h1);
        settle();
        chk("flag_once", 32'h0, {31'h0, comparator_irq_flag});
        // clear write lands at the very edge the new rising edge is seen
        apb(1'b1, `ACD_ADDR_CTRL1, 32'h1 << `ACD_C1_INTP);
        vp <= 8'hc8;
        repeat (3) @(posedge clk);
        apb(1'b1, `ACD_ADDR_FLAG, 32'h1);
        chk("flag_set_wins", 32'h1, {31'h0, comparator_irq_flag});
    endtask : t_edges
    task automatic t_pin();
        vp <= 8'hc8;
        apb(1'b1, `ACD_ADDR_PINSEL, b_cmp | b_dir);
        settle();
        chk("pin_oe_input", 32'h0, {31'h0, pin_oe});
        apb(1'b1, `ACD_ADDR_PINSEL, b_cmp);
        settle();
        chk("pin_oe", 32'h1, {31'h0, pin_oe});
        chk("pin_out", 32'h1, {31'h0, pin_out});
        apb(1'b1, `ACD_ADDR_PINSEL, 32'h1);
        settle();
        chk("pin_other", 32'h0, {31'h0, pin_out});
        apb(1'b1, `ACD_ADDR_PINSEL, b_cmp);
    endtask : t_pin
    task automatic t_sync();
        vp <= 8'h32;
        apb(1'b1, `ACD_ADDR_CTRL0, b_en | b_syn);
        tclk_run <= 1'b1;
        repeat (40) @(posedge clk);
        tclk_run <= 1'b0;
        repeat (40) @(posedge clk);
        vp <= 8'hc8;
        settle();
        apb(1'b0, `ACD_ADDR_CTRL0, 32'h0);
        chk("sync_out_bit", 32'h1, {31'h0, rd[`ACD_C0_OUT]});
        chk("sync_gate_hold", 32'h0, {31'h0, timer_gate});
        chk("sync_pin_hold", 32'h0, {31'h0, pin_out});
        tclk_run <= 1'b1;
        repeat (40) @(posedge clk);
        chk("sync_gate", 32'h1, {31'h0, timer_gate});
        chk("sync_pin", 32'h1, {31'h0, pin_out});
        tclk_run <= 1'b0;
    endtask : t_sync
    // cuts a hang short well beyond the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        {clk, psel, penable, pwrite, tclk_run} = '0;
        {paddr, pwdata, err_total, cmp_count, cycles} = '0;
        sys_rst = 1'b1;
        vp = 8'h32;
        vn = 8'h64;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_polarity();
        t_edges();
        t_pin();
        t_sync();
        finish_test();
    end
endmodule : tb
